// ===== reset_supply_defines.svh
// offsets, field positions, reset values and timing counts of the reset and supply monitor
`ifndef RESET_SUPPLY_DEFINES_SVH
`define RESET_SUPPLY_DEFINES_SVH

// ----------------------------------------------------------------
// register indexes, byte address is four times the index
// ----------------------------------------------------------------
`define RAM_PAGE_INDEX        10'h0f3
`define CONFIG_INDEX          10'h0f5
`define STATUS_INDEX          10'h010
`define MASK_INDEX            10'h011
`define SEQ_STATE_INDEX       10'h012

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_DETECTOR_OFF_BIT  3'd0
`define CFG_ACTION_BIT        3'd1
`define CFG_WARNING_BIT       3'd2
`define CFG_FAILURE_BIT       3'd3
`define ST_WARNING_BIT        2'd0
`define ST_FAILURE_BIT        2'd1
`define ST_WATCHDOG_BIT       2'd2
`define ST_EXT_RESET_BIT      2'd3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CONFIG_RESET          8'h00
`define RAM_PAGE_RESET        8'h00
`define STATUS_RESET          4'h0
`define MASK_RESET            4'h0
`define VECTOR_LOW_ADDR       16'hfffe
`define VECTOR_HIGH_ADDR      16'hffff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS         5
`define STARTUP_TIME_NS       65500000
`define STARTUP_CYCLES        (`STARTUP_TIME_NS / `CLK_PERIOD_NS)
`define EXTRA_CYCLES          4'h7
`define EXT_RESET_MIN_CYCLES  4'h8

`endif

// ===== reset_supply_pkg.sv
// types shared by the reset and supply monitor
package reset_supply_pkg;

  typedef enum logic [2:0] {
    hold,
    startup_wait,
    extra_wait,
    fetch_low,
    fetch_high,
    load_pc,
    running
  } seq_state_type;

  typedef struct packed {
    logic reserved;
    logic booster_enable;
    logic peripheral_clock_off;
    logic sub_clock_select;
    logic supply_failure_flag;
    logic low_supply_warning_flag;
    logic failure_action_select;
    logic supply_detector_off;
  } config_type;

  typedef struct packed {
    logic ext_reset;
    logic watchdog;
    logic failure;
    logic warning;
  } event_type;

endpackage

// ===== pin_sync.sv
// three-stage synchroniser, output moves once the last two stages agree
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ----------------------------------------------------------------
  // chain, stage1 feeds stage2 only
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= RESET_LEVEL;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

endmodule

// ===== reset_supply_monitor.sv
// reset sequencing and supply voltage supervision with an apb register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`include "reset_supply_defines.svh"
module reset_supply_monitor #(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_reset_req,
  input  wire logic        below_warning_level,
  input  wire logic        below_failure_level,
  output logic      [15:0] vector_addr,
  output logic             vector_read,
  input  wire logic [7:0]  vector_data,
  output logic      [15:0] program_counter,
  output logic             pc_load,
  output logic             core_reset_n,
  output logic             core_freeze,
  output logic      [1:0]  ram_page_select,
  output logic             page_flag,
  output logic             main_clock_select,
  output logic             peripheral_clock_on,
  output logic             supply_detector_on,
  output logic             booster_on,
  output logic             low_supply_warning_flag,
  output logic             supply_failure_flag,
  output logic             irq
);

  reset_supply_pkg::seq_state_type state;
  reset_supply_pkg::seq_state_type next_state;
  reset_supply_pkg::config_type    cfg;
  reset_supply_pkg::event_type     status;
  reset_supply_pkg::event_type     mask;
  reset_supply_pkg::event_type     events;

  logic        pin_level;
  logic        warn_level;
  logic        fail_level;
  logic [3:0]  low_count;
  logic        ext_reset_seen;
  logic        reset_request;
  logic        warn_prev;
  logic [23:0] wait_count;
  logic [7:0]  vector_low;
  logic        setup_phase;
  logic        access_phase;
  logic        wr_access;
  logic        addr_ok;
  logic        lane0;

  function automatic logic is_index(input logic [11:0] addr, input logic [9:0] index);
    is_index = (addr[11:2] == index) && (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // synchronise pin inputs
  pin_sync #(.RESET_LEVEL(1'b0)) reset_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (reset_pin_n),
    .level   (pin_level)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) warn_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (below_warning_level),
    .level   (warn_level)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) fail_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (below_failure_level),
    .level   (fail_level)
  );

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // count low pin cycles, short glitches ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_count <= 4'h0;
    end else if (pin_level) begin
      low_count <= 4'h0;
    end else if (low_count != `EXT_RESET_MIN_CYCLES) begin
      low_count <= low_count + 4'h1;
    end
  end

  assign ext_reset_seen = (low_count == `EXT_RESET_MIN_CYCLES);

  // failure with reset action holds reset
  assign reset_request = ext_reset_seen || watchdog_reset_req ||
                         (cfg.supply_failure_flag && cfg.failure_action_select);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite && addr_ok;
  assign lane0        = pstrb[0];
  assign pready       = 1'b1;
  assign pslverr      = access_phase && !addr_ok;
  assign addr_ok      = is_index(paddr, `RAM_PAGE_INDEX) || is_index(paddr, `CONFIG_INDEX) ||
                        is_index(paddr, `STATUS_INDEX) || is_index(paddr, `MASK_INDEX) ||
                        is_index(paddr, `SEQ_STATE_INDEX);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      reset_supply_pkg::hold: begin
        if (!reset_request && pin_level) begin
          next_state = reset_supply_pkg::startup_wait;
        end
      end
      reset_supply_pkg::startup_wait: begin
        if (wait_count == 24'(STARTUP_CYCLES - 1)) begin
          next_state = reset_supply_pkg::extra_wait;
        end
      end
      reset_supply_pkg::extra_wait: begin
        if (wait_count == 24'(`EXTRA_CYCLES - 4'h1)) begin
          next_state = reset_supply_pkg::fetch_low;
        end
      end
      reset_supply_pkg::fetch_low: begin
        next_state = reset_supply_pkg::fetch_high;
      end
      reset_supply_pkg::fetch_high: begin
        next_state = reset_supply_pkg::load_pc;
      end
      reset_supply_pkg::load_pc: begin
        next_state = reset_supply_pkg::running;
      end
      reset_supply_pkg::running: begin
        next_state = reset_supply_pkg::running;
      end
      default: begin
        next_state = reset_supply_pkg::hold;
      end
    endcase
    if (reset_request) begin
      next_state = reset_supply_pkg::hold;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= reset_supply_pkg::hold;
    end else begin
      state <= next_state;
    end
  end

  // start-up delay then seven more periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_count <= 24'h000000;
    end else if (next_state != state) begin
      wait_count <= 24'h000000;
    end else begin
      wait_count <= wait_count + 24'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_addr <= 16'h0000;
      vector_read <= 1'b0;
      vector_low  <= 8'h00;
    end else begin
      vector_read <= (next_state == reset_supply_pkg::fetch_low) ||
                     (next_state == reset_supply_pkg::fetch_high);
      if (next_state == reset_supply_pkg::fetch_low) begin
        vector_addr <= `VECTOR_LOW_ADDR;
      end else if (next_state == reset_supply_pkg::fetch_high) begin
        vector_addr <= `VECTOR_HIGH_ADDR;
      end
      if (state == reset_supply_pkg::fetch_low) begin
        vector_low <= vector_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= 16'h0000;
      pc_load         <= 1'b0;
    end else begin
      pc_load <= (state == reset_supply_pkg::load_pc);
      // high byte stands only while its address is shown
      if (state == reset_supply_pkg::fetch_high) begin
        program_counter <= {vector_data, vector_low};
      end
    end
  end

  // core held, data memory left alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n <= 1'b0;
      core_freeze  <= 1'b0;
    end else begin
      core_reset_n <= (next_state == reset_supply_pkg::running);
      core_freeze  <= cfg.supply_failure_flag && !cfg.failure_action_select;
    end
  end

  // ----------------------------------------------------------------
  // configuration and page registers
  // ----------------------------------------------------------------
  // reset values restored each sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_page_select <= 2'b00;
      page_flag       <= 1'b0;
    end else if (state == reset_supply_pkg::hold) begin
      ram_page_select <= 2'b00;
      page_flag       <= 1'b0;
    end else if (wr_access && lane0 && is_index(paddr, `RAM_PAGE_INDEX)) begin
      ram_page_select <= pwdata[1:0];
      page_flag       <= pwdata[4];
    end
  end

  // one writer for the whole register, flags included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `CONFIG_RESET;
    end else begin
      cfg.low_supply_warning_flag <= warn_level && !cfg.supply_detector_off;
      // cleared only by writing one, set wins
      if (fail_level && !cfg.supply_detector_off) begin
        cfg.supply_failure_flag <= 1'b1;
      end else if (wr_access && lane0 && is_index(paddr, `CONFIG_INDEX) &&
                   pwdata[`CFG_FAILURE_BIT]) begin
        cfg.supply_failure_flag <= 1'b0;
      end
      if (state == reset_supply_pkg::hold) begin
        cfg.booster_enable       <= 1'b0;
        cfg.peripheral_clock_off <= 1'b0;
        cfg.sub_clock_select     <= 1'b0;
        cfg.supply_detector_off  <= 1'b0;
      end else if (wr_access && lane0 && is_index(paddr, `CONFIG_INDEX)) begin
        cfg.supply_detector_off   <= pwdata[`CFG_DETECTOR_OFF_BIT];
        cfg.failure_action_select <= pwdata[`CFG_ACTION_BIT];
        cfg.sub_clock_select      <= pwdata[4];
        cfg.peripheral_clock_off  <= pwdata[5];
        cfg.booster_enable        <= pwdata[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // clock, detector, booster and supply flag outputs
  // ----------------------------------------------------------------

  assign main_clock_select       = !cfg.sub_clock_select;
  assign peripheral_clock_on     = !cfg.peripheral_clock_off;
  assign supply_detector_on      = !cfg.supply_detector_off;
  assign booster_on              = cfg.booster_enable;
  assign low_supply_warning_flag = cfg.low_supply_warning_flag;
  assign supply_failure_flag     = cfg.supply_failure_flag;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_prev <= 1'b0;
    end else begin
      warn_prev <= cfg.low_supply_warning_flag;
    end
  end

  // rising edge for warning only, failure gated by its flag; both reset sources are levels and refire after clear
  assign events = {ext_reset_seen, watchdog_reset_req,
                   fail_level && !cfg.supply_detector_off && !cfg.supply_failure_flag,
                   cfg.low_supply_warning_flag && !warn_prev};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `STATUS_RESET;
    end else if (wr_access && lane0 && is_index(paddr, `STATUS_INDEX)) begin
      status <= (status & ~pwdata[3:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= `MASK_RESET;
    end else if (wr_access && lane0 && is_index(paddr, `MASK_INDEX)) begin
      mask <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      if (is_index(paddr, `RAM_PAGE_INDEX)) begin
        prdata <= {27'h0, page_flag, 2'b00, ram_page_select};
      end else if (is_index(paddr, `CONFIG_INDEX)) begin
        prdata <= {24'h000000, cfg};
      end else if (is_index(paddr, `STATUS_INDEX)) begin
        prdata <= {28'h0000000, status};
      end else if (is_index(paddr, `MASK_INDEX)) begin
        prdata <= {28'h0000000, mask};
      end else if (is_index(paddr, `SEQ_STATE_INDEX)) begin
        prdata <= {29'h0, state};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

// ===== reset_supply_monitor_props.sv
// port checker of the reset and supply monitor, bound into the design
`timescale 1ns/100ps
module reset_supply_monitor_props #(
  parameter int STARTUP_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        reset_pin_n,
  input wire logic        watchdog_reset_req,
  input wire logic        below_warning_level,
  input wire logic        below_failure_level,
  input wire logic [15:0] vector_addr,
  input wire logic        vector_read,
  input wire logic [7:0]  vector_data,
  input wire logic [15:0] program_counter,
  input wire logic        pc_load,
  input wire logic        core_reset_n,
  input wire logic        core_freeze,
  input wire logic [1:0]  ram_page_select,
  input wire logic        page_flag,
  input wire logic        main_clock_select,
  input wire logic        peripheral_clock_on,
  input wire logic        supply_detector_on,
  input wire logic        booster_on,
  input wire logic        low_supply_warning_flag,
  input wire logic        supply_failure_flag
);
  // ------------------------------------------------
  // helper state
  // ------------------------------------------------
  logic [7:0] lo_seen;
  logic [7:0] hi_seen;
  int         low_count;
  // memory answers at once, so bytes are taken as each address shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_seen <= 8'h00;
      hi_seen <= 8'h00;
    end else if (vector_read && vector_addr == 16'hfffe) begin
      lo_seen <= vector_data;
    end else if (vector_read && vector_addr == 16'hffff) begin
      hi_seen <= vector_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_count <= 0;
    end else if (core_reset_n) begin
      low_count <= 0;
    end else begin
      low_count <= low_count + 1;
    end
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  vector_order_a: assert property (vector_read && vector_addr == 16'hfffe
    |=> vector_read && vector_addr == 16'hffff) else $error("vector fetch order wrong");
  pc_pairing_a: assert property (pc_load
    |-> program_counter == {hi_seen, lo_seen}) else $error("program counter not vector");
  load_release_a: assert property ($rose(core_reset_n)
    |-> pc_load && low_count >= STARTUP_CYCLES + 7) else $error("release too early");
  init_state_a: assert property ($rose(core_reset_n) |-> ram_page_select == 2'b00
    && !page_flag && main_clock_select && peripheral_clock_on && supply_detector_on
    && !booster_on) else $error("state not initialised at release");
  watchdog_reset_a: assert property (watchdog_reset_req
    |-> ##[1:3] !core_reset_n) else $error("watchdog request ignored");
  pin_reset_a: assert property ((!reset_pin_n)[*8] ##1 (!reset_pin_n)[*6]
    |-> ##[0:4] !core_reset_n) else $error("long pin reset ignored");
  warn_follow_a: assert property ((!below_warning_level)[*8]
    |-> !low_supply_warning_flag) else $error("warning did not clear");
  warn_set_a: assert property ((below_warning_level && supply_detector_on)[*8]
    |-> low_supply_warning_flag) else $error("warning did not set");
  fail_set_a: assert property ((below_failure_level && supply_detector_on)[*8]
    |-> supply_failure_flag) else $error("failure flag did not set");
  fail_sticky_a: assert property (supply_failure_flag && !(psel && penable && pwrite)
    |=> supply_failure_flag) else $error("failure flag cleared itself");
  freeze_cause_a: assert property (core_freeze
    |-> supply_failure_flag || $past(supply_failure_flag)) else $error("freeze without flag");
endmodule

bind reset_supply_monitor reset_supply_monitor_props #(
  .STARTUP_CYCLES(STARTUP_CYCLES)
) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .reset_pin_n, .watchdog_reset_req,
  .below_warning_level, .below_failure_level, .vector_addr, .vector_read, .vector_data,
  .program_counter, .pc_load, .core_reset_n, .core_freeze, .ram_page_select, .page_flag,
  .main_clock_select, .peripheral_clock_on, .supply_detector_on, .booster_on,
  .low_supply_warning_flag, .supply_failure_flag
);

// ===== supply_partner.sv
// board reset circuit, supply comparators and top of program memory
`timescale 1ns/100ps
module supply_partner (
  input  wire logic        board_reset,
  input  wire logic [1:0]  supply_code,
  input  wire logic [7:0]  vec_lo,
  input  wire logic [7:0]  vec_hi,
  input  wire logic [15:0] vector_addr,
  input  wire logic        vector_read,
  output logic             reset_pin_n,
  output logic             below_warning_level,
  output logic             below_failure_level,
  output logic      [7:0]  vector_data
);
  assign reset_pin_n = !board_reset;
  assign below_warning_level = supply_code != 2'd0;
  assign below_failure_level = supply_code == 2'd2;
  // vector bytes
  // unread memory shows inverted data so a late sample is caught
  assign vector_data = vector_read ? (vector_addr[0] ? vec_hi : vec_lo)
                                   : ~(vector_addr[0] ? vec_hi : vec_lo);
endmodule

// ===== tb_reset_supply_monitor.sv
// self-checking testbench of the reset and supply monitor
`timescale 1ns/100ps
`include "reset_supply_defines.svh"
module tb_reset_supply_monitor;
  localparam int          STARTUP = 20;
  localparam logic [11:0] PAGE_A  = {`RAM_PAGE_INDEX, 2'b00};
  localparam logic [11:0] CFG_A   = {`CONFIG_INDEX, 2'b00};
  localparam logic [11:0] STAT_A  = {`STATUS_INDEX, 2'b00};
  localparam logic [11:0] MASK_A  = {`MASK_INDEX, 2'b00};
  localparam logic [11:0] SEQ_A   = {`SEQ_STATE_INDEX, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pc_load, irq;
  logic        reset_pin_n, watchdog_reset_req, below_warning_level, below_failure_level;
  logic        vector_read, core_reset_n, core_freeze, page_flag, main_clock_select;
  logic        peripheral_clock_on, supply_detector_on, booster_on, board_reset, rerr;
  logic        low_supply_warning_flag, supply_failure_flag;
  logic [1:0]  ram_page_select, supply_code;
  logic [3:0]  pstrb;
  logic [6:0]  init_view;
  logic [7:0]  vector_data, vec_lo, vec_hi, cfg, rp;
  logic [11:0] paddr;
  logic [15:0] vector_addr, program_counter;
  logic [31:0] pwdata, prdata, rdata;
  int          mismatches, comparisons, n;

  assign init_view = {ram_page_select, page_flag, main_clock_select, peripheral_clock_on,
                      supply_detector_on, booster_on};

  reset_supply_monitor #(.STARTUP_CYCLES(STARTUP)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
    .prdata, .reset_pin_n, .watchdog_reset_req, .below_warning_level, .below_failure_level,
    .vector_addr, .vector_read, .vector_data, .program_counter, .pc_load, .core_reset_n,
    .core_freeze, .ram_page_select, .page_flag, .main_clock_select, .peripheral_clock_on,
    .supply_detector_on, .booster_on, .low_supply_warning_flag, .supply_failure_flag, .irq
  );
  supply_partner u_partner (
    .board_reset, .supply_code, .vec_lo, .vec_hi, .vector_addr, .vector_read,
    .reset_pin_n, .below_warning_level, .below_failure_level, .vector_data
  );

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic summarize();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic expire();
    mismatches++;
    summarize();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask
  function automatic logic [6:0] view_of(input logic [7:0] page, input logic [7:0] conf);
    return {page[1:0], page[4], !conf[4], !conf[5], !conf[0], conf[6]};
  endfunction
  // one transfer, then an idle cycle so psel never toggles twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) expire();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rdata, e);
    check(rerr, ee);
  endtask
  task automatic wait_for(ref logic s, input logic want);
    int k;
    k = 0;
    while (s !== want && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 5000) expire();
    n = k;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, watchdog_reset_req, board_reset} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    supply_code = 2'd0;
    mismatches = 0;
    comparisons = 0;
    rdata = $urandom(47523);
    vec_lo = 8'($urandom);
    vec_hi = 8'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(core_reset_n, 1'b1);
    check(n >= STARTUP + 7, 1'b1);
    check(pc_load, 1'b1);
    check(program_counter, {vec_hi, vec_lo});
    check(init_view, view_of(`RAM_PAGE_RESET, `CONFIG_RESET));
    rd(CFG_A, 32'h0, 1'b0);
    rd(PAGE_A, 32'h0, 1'b0);
    rd(SEQ_A, 32'h6, 1'b0);
    rd(12'h3fc, 32'h0, 1'b1);
    rd(CFG_A + 12'h001, 32'h0, 1'b1);
    $display("test power-up done");
    rp = 8'($urandom) & 8'h13;
    cfg = (8'($urandom) & 8'h70) | 8'h40;
    apb(1'b1, PAGE_A, {24'h0, rp});
    apb(1'b1, CFG_A, {24'h0, cfg});
    rd(CFG_A, {24'h0, cfg}, 1'b0);
    check(init_view, view_of(rp, cfg));
    watchdog_reset_req <= 1'b1;
    @(posedge pclk);
    watchdog_reset_req <= 1'b0;
    wait_for(core_reset_n, 1'b0);
    wait_for(core_reset_n, 1'b1);
    check(n >= STARTUP + 7, 1'b1);
    check(init_view, view_of(`RAM_PAGE_RESET, `CONFIG_RESET));
    check(program_counter, {vec_hi, vec_lo});
    rd(STAT_A, 32'h4, 1'b0);
    apb(1'b1, STAT_A, 32'h4);
    $display("test watchdog done");
    // too short a pin pulse breaks the board rule on purpose
    board_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    board_reset <= 1'b0;
    repeat (30) @(posedge pclk);
    check(core_reset_n, 1'b1);
    board_reset <= 1'b1;
    repeat (16) @(posedge pclk);
    board_reset <= 1'b0;
    wait_for(core_reset_n, 1'b0);
    wait_for(core_reset_n, 1'b1);
    rd(STAT_A, 32'h8, 1'b0);
    apb(1'b1, STAT_A, 32'h8);
    $display("test pin reset done");
    apb(1'b1, MASK_A, 32'h2);
    supply_code <= 2'd1;
    wait_for(low_supply_warning_flag, 1'b1);
    check(n <= 8, 1'b1);
    rd(CFG_A, 32'h4, 1'b0);
    check(irq, 1'b0);
    apb(1'b1, MASK_A, 32'h3);
    @(posedge pclk);
    check(irq, 1'b1);
    supply_code <= 2'd0;
    wait_for(low_supply_warning_flag, 1'b0);
    check(n <= 8, 1'b1);
    rd(STAT_A, 32'h1, 1'b0);
    apb(1'b1, STAT_A, 32'h1);
    @(posedge pclk);
    check(irq, 1'b0);
    $display("test warning done");
    supply_code <= 2'd2;
    wait_for(supply_failure_flag, 1'b1);
    repeat (2) @(posedge pclk);
    check({core_freeze, core_reset_n}, 2'b11);
    supply_code <= 2'd0;
    repeat (20) @(posedge pclk);
    check(supply_failure_flag, 1'b1);
    apb(1'b1, CFG_A, 32'h8);
    @(posedge pclk);
    check({supply_failure_flag, core_freeze}, 2'b00);
    apb(1'b1, CFG_A, 32'h2);
    supply_code <= 2'd2;
    wait_for(core_reset_n, 1'b0);
    supply_code <= 2'd0;
    repeat (40) @(posedge pclk);
    check(core_reset_n, 1'b0);
    apb(1'b1, CFG_A, 32'ha);
    wait_for(core_reset_n, 1'b1);
    check(pc_load, 1'b1);
    $display("test failure done");
    apb(1'b1, CFG_A, 32'h3);
    supply_code <= 2'd2;
    repeat (20) @(posedge pclk);
    check({supply_detector_on, low_supply_warning_flag, supply_failure_flag}, 3'b000);
    check(core_reset_n, 1'b1);
    supply_code <= 2'd0;
    $display("test detector off done");
    summarize();
  end
endmodule
